// >>> core/cscr_nv_ctrl.v
// Nonvolatile memory sequencer: restores the image after reset and saves it on request.
`timescale 1ns/1ns
`include "cscr_regs.vh"
module cscr_nv_ctrl (
  input  wire        clk,        // System clock.
  input  wire        resetn,     // Asynchronous reset, active low.
  input  wire        store_req,  // Save request pulse.
  input  wire [39:0] img_in,     // Active configuration, entry 0 in the low byte.
  output wire        load_we,    // Restored byte write pulse.
  output wire [2:0]  load_idx,   // Restored byte entry index.
  output wire [7:0]  load_data,  // Restored byte value.
  output wire        busy,       // Sequencer active.
  output reg  [2:0]  nv_addr,    // Memory word address.
  output reg         nv_re,      // Memory read strobe.
  output reg         nv_we,      // Memory write strobe.
  output reg  [7:0]  nv_wdata,   // Memory write data.
  input  wire [7:0]  nv_rdata    // Memory read data, one cycle after nv_re.
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_CHECK = 3'h1;
  localparam ST_MARK  = 3'h2;
  localparam ST_LOAD  = 3'h3;
  localparam ST_DRAIN = 3'h4;
  localparam ST_SAVE  = 3'h5;

  reg [2:0] state_ff, nxt_state;
  reg [2:0] cnt_ff, nxt_cnt;
  reg       pend_ff;
  reg [2:0] pidx_ff;

  // A blank memory has no marker, so the reset defaults are kept in that case.
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nv_addr   = cnt_ff;
    nv_re     = 1'b0;
    nv_we     = 1'b0;
    nv_wdata  = 8'h00;
    case (state_ff)
      ST_CHECK: begin
        nv_re     = 1'b1;
        nv_addr   = `CSCR_NV_MARK_ADDR;
        nxt_state = ST_MARK;
      end
      ST_MARK: begin
        nxt_cnt   = 3'h0;
        nxt_state = (nv_rdata == `CSCR_NV_MARK) ? ST_LOAD : ST_IDLE;
      end
      ST_LOAD: begin
        nv_re   = 1'b1;
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == `CSCR_NV_LAST) begin
          nxt_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        nxt_state = ST_IDLE;
      end
      ST_SAVE: begin
        nv_we = 1'b1;
        if (cnt_ff == `CSCR_NV_MARK_ADDR) begin
          nv_wdata  = `CSCR_NV_MARK;
          nxt_state = ST_IDLE;
        end else begin
          nv_wdata = img_in[cnt_ff*8 +: 8];
          nxt_cnt  = cnt_ff + 3'h1;
        end
      end
      ST_IDLE: begin
        if (store_req) begin
          nxt_cnt   = 3'h0;
          nxt_state = ST_SAVE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // The restore starts on its own at reset release, giving power-up without software.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_CHECK;
      cnt_ff   <= 3'h0;
      pend_ff  <= 1'b0;
      pidx_ff  <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pend_ff  <= (state_ff == ST_LOAD);
      pidx_ff  <= cnt_ff;
    end
  end

  assign load_we   = pend_ff;
  assign load_idx  = pidx_ff;
  assign load_data = nv_rdata;
  assign busy      = (state_ff != ST_IDLE);
endmodule // cscr_nv_ctrl

// >>> core/cscr_regs.vh
// Register offsets, field positions, reset values and codes of the clock source routing block.
// Contract
// - Power field code 00b runs the PLL and code 01b holds it in asynchronous power-down.
// - Source-select bit 1b routes the internal VCO to distribution and 0b routes the external clock input.
// - Divider-bypass bit 0b feeds distribution through the VCO divider and 1b passes the source directly.
// - The three-bit divider code selects a ratio of one to six, with code 000b giving divide-by-two.
// - After reset the PLL is powered down, the divider code is 000b, the divider is used and CLK is selected.
// - PFD polarity bit 0b means positive polarity and 1b means negative polarity.
// - Setting the calibrate bit and then pulsing the update strobe starts a VCO calibration; the code starts one only when the active bit was 0b.
// - With the PLL on and the external clock selected, the VCO is powered off and CLK feeds the prescaler.
// - The programmed configuration can be saved to nonvolatile memory and is restored at power-up.
`ifndef CSCR_REGS_VH
`define CSCR_REGS_VH

`define CSCR_ADDR_W          13
`define CSCR_OFS_PLL_CTRL    13'h010
`define CSCR_OFS_CAL_CTRL    13'h018
`define CSCR_OFS_REF_EN      13'h01c
`define CSCR_OFS_STATUS      13'h01f
`define CSCR_OFS_VCO_DIV     13'h1e0
`define CSCR_OFS_ROUTE       13'h1e1
`define CSCR_OFS_UPDATE      13'h232
`define CSCR_OFS_NV_CTRL     13'hb02

`define CSCR_PWR_LSB         0
`define CSCR_PWR_MSB         1
`define CSCR_PFD_POL_BIT     7
`define CSCR_CAL_BIT         0
`define CSCR_REF_MSB         2
`define CSCR_DIV_MSB         2
`define CSCR_BYP_BIT         0
`define CSCR_VCO_SEL_BIT     1
`define CSCR_UPD_BIT         0
`define CSCR_NV_STORE_BIT    0

`define CSCR_PWR_NORMAL      2'h0
`define CSCR_PWR_DOWN        2'h1

`define CSCR_RST_PLL_CTRL    8'h01
`define CSCR_RST_CAL_CTRL    8'h00
`define CSCR_RST_REF_EN      8'h00
`define CSCR_RST_VCO_DIV     8'h00
`define CSCR_RST_ROUTE       8'h00

`define CSCR_IDX_PLL         3'h0
`define CSCR_IDX_CAL         3'h1
`define CSCR_IDX_REF         3'h2
`define CSCR_IDX_DIV         3'h3
`define CSCR_IDX_ROUTE       3'h4
`define CSCR_NV_LAST         3'h4
`define CSCR_NV_MARK_ADDR    3'h5
`define CSCR_NV_MARK         8'ha5

`define CSCR_SPI_INSTR_LAST  5'h0f
`define CSCR_SPI_DATA_LAST   5'h17

`endif

// >>> core/cscr_spi_port.v
// Serial control port slave: one instruction word and one data byte per frame.
`timescale 1ns/1ns
`include "cscr_regs.vh"
module cscr_spi_port (
  input  wire       clk,        // System clock.
  input  wire       resetn,     // Asynchronous reset, active low.
  input  wire       sclk,       // Serial clock pin.
  input  wire       csb_n,      // Chip select pin, active low.
  input  wire       sdi,        // Serial data in pin.
  output wire       sdo,        // Serial data out.
  output wire       sdo_oe,     // Serial data out enable.
  output wire       reg_wr,     // Register write pulse.
  output wire       reg_rd,     // Register read pulse.
  output wire [12:0] reg_addr,  // Register address.
  output wire [7:0] reg_wdata,  // Register write data.
  input  wire [7:0] reg_rdata   // Register read data, valid with reg_rd.
);
  reg        sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  reg        csb_s1_ff, csb_s2_ff;
  reg        sdi_s1_ff, sdi_s2_ff;
  reg  [4:0] cnt_ff;
  reg [14:0] sh_ff;
  reg        rw_ff;
  reg [12:0] addr_ff;
  reg  [7:0] wdata_ff;
  reg  [7:0] rdat_ff;
  reg        wr_ff, rd_ff, rd_ph_ff, sdo_ff;
  wire       rise = sclk_s2_ff & ~sclk_s3_ff;
  wire       fall = ~sclk_s2_ff & sclk_s3_ff;

  // Pins pass two flops first; the third sclk flop only serves the edge detector.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      csb_s1_ff  <= 1'b1;
      csb_s2_ff  <= 1'b1;
      sdi_s1_ff  <= 1'b0;
      sdi_s2_ff  <= 1'b0;
    end else begin
      sclk_s1_ff <= sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      csb_s1_ff  <= csb_n;
      csb_s2_ff  <= csb_s1_ff;
      sdi_s1_ff  <= sdi;
      sdi_s2_ff  <= sdi_s1_ff;
    end
  end

  // Frame engine; sclk must stay slow against clk since edges are found by sampling.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff   <= 5'h00;
      sh_ff    <= 15'h0000;
      rw_ff    <= 1'b0;
      addr_ff  <= 13'h0000;
      wdata_ff <= 8'h00;
      rdat_ff  <= 8'h00;
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
      rd_ph_ff <= 1'b0;
      sdo_ff   <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      if (csb_s2_ff) begin
        cnt_ff   <= 5'h00;
        rd_ph_ff <= 1'b0;
      end else begin
        if (rise && cnt_ff <= `CSCR_SPI_DATA_LAST) begin
          sh_ff  <= {sh_ff[13:0], sdi_s2_ff};
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == `CSCR_SPI_INSTR_LAST) begin
            rw_ff   <= sh_ff[14];
            addr_ff <= {sh_ff[11:0], sdi_s2_ff};
            rd_ff   <= sh_ff[14];
          end
          if (cnt_ff == `CSCR_SPI_DATA_LAST && !rw_ff) begin
            wdata_ff <= {sh_ff[6:0], sdi_s2_ff};
            wr_ff    <= 1'b1;
          end
        end
        if (rd_ff) begin
          rdat_ff  <= reg_rdata;
          rd_ph_ff <= 1'b1;
        end else if (fall && rd_ph_ff) begin
          sdo_ff  <= rdat_ff[7];
          rdat_ff <= {rdat_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign sdo       = sdo_ff;
  assign sdo_oe    = rd_ph_ff;
  assign reg_wr    = wr_ff;
  assign reg_rd    = rd_ff;
  assign reg_addr  = addr_ff;
  assign reg_wdata = wdata_ff;
endmodule // cscr_spi_port

// >>> core/cscr_top.v
// Clock source routing configuration: staged registers, update commit, decoded controls.
`timescale 1ns/1ns
`include "cscr_regs.vh"
module cscr_top (
  input  wire       clk,                 // System clock, 100 MHz.
  input  wire       resetn,              // Asynchronous reset, active low.
  input  wire       spi_sclk,            // Serial clock pin.
  input  wire       spi_csb_n,           // Chip select pin, active low.
  input  wire       spi_sdi,             // Serial data in pin.
  output wire       spi_sdo,             // Serial data out.
  output wire       spi_sdo_oe,          // Serial data out enable.
  output wire [2:0] nv_addr,             // Nonvolatile memory address.
  output wire       nv_re,               // Nonvolatile memory read strobe.
  output wire       nv_we,               // Nonvolatile memory write strobe.
  output wire [7:0] nv_wdata,            // Nonvolatile memory write data.
  input  wire [7:0] nv_rdata,            // Nonvolatile memory read data.
  output wire [1:0] pll_power_mode,      // Active power field.
  output wire       pll_enabled,         // PLL running.
  output wire       pll_powered_down,    // PLL held off.
  output wire       vco_source_sel,      // Internal VCO routed to distribution.
  output wire       vco_enabled,         // Internal VCO powered.
  output wire       ext_to_prescaler,    // External input feeds the prescaler.
  output wire       div_bypass,          // VCO divider skipped.
  output wire [2:0] vco_div_code,        // Active divider code.
  output reg  [2:0] vco_div_ratio,       // Division ratio, 1 to 6.
  output wire       pfd_polarity_neg,    // PFD polarity negative.
  output wire [2:0] ref_input_enable,    // Reference input enables.
  output wire       vco_cal_start        // Calibration start pulse.
);
  localparam [39:0] RST_IMG = {`CSCR_RST_ROUTE, `CSCR_RST_VCO_DIV, `CSCR_RST_REF_EN,
                               `CSCR_RST_CAL_CTRL, `CSCR_RST_PLL_CTRL};
  localparam NREG = 5;

  wire        reg_wr, reg_rd, load_we, nv_busy;
  wire [12:0] reg_addr;
  wire  [7:0] reg_wdata, load_data;
  wire  [2:0] load_idx;
  reg   [7:0] reg_rdata;
  reg   [2:0] wr_idx;
  reg         wr_hit;
  reg   [7:0] stage_ff [0:NREG-1];
  reg   [7:0] act_ff   [0:NREG-1];
  reg         cal_start_ff;
  wire [39:0] act_img;
  wire        upd = reg_wr && reg_addr == `CSCR_OFS_UPDATE && reg_wdata[`CSCR_UPD_BIT];
  wire        store_req = reg_wr && reg_addr == `CSCR_OFS_NV_CTRL && reg_wdata[`CSCR_NV_STORE_BIT];

  cscr_spi_port u_spi (
    .clk       (clk),
    .resetn    (resetn),
    .sclk      (spi_sclk),
    .csb_n     (spi_csb_n),
    .sdi       (spi_sdi),
    .sdo       (spi_sdo),
    .sdo_oe    (spi_sdo_oe),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  cscr_nv_ctrl u_nv (
    .clk       (clk),
    .resetn    (resetn),
    .store_req (store_req),
    .img_in    (act_img),
    .load_we   (load_we),
    .load_idx  (load_idx),
    .load_data (load_data),
    .busy      (nv_busy),
    .nv_addr   (nv_addr),
    .nv_re     (nv_re),
    .nv_we     (nv_we),
    .nv_wdata  (nv_wdata),
    .nv_rdata  (nv_rdata)
  );

  // Address decode of the staged configuration registers; other offsets are not stored.
  always @* begin
    wr_hit = reg_wr;
    case (reg_addr)
      `CSCR_OFS_PLL_CTRL: wr_idx = `CSCR_IDX_PLL;
      `CSCR_OFS_CAL_CTRL: wr_idx = `CSCR_IDX_CAL;
      `CSCR_OFS_REF_EN:   wr_idx = `CSCR_IDX_REF;
      `CSCR_OFS_VCO_DIV:  wr_idx = `CSCR_IDX_DIV;
      `CSCR_OFS_ROUTE:    wr_idx = `CSCR_IDX_ROUTE;
      default: begin
        wr_idx = 3'h0;
        wr_hit = 1'b0;
      end
    endcase
  end

  // Staging and active copies per entry; a restore from memory overrides both at once.
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage_ff[gi] <= RST_IMG[gi*8 +: 8];
          act_ff[gi]   <= RST_IMG[gi*8 +: 8];
        end else if (load_we && load_idx == gi) begin
          stage_ff[gi] <= load_data;
          act_ff[gi]   <= load_data;
        end else begin
          if (wr_hit && wr_idx == gi) begin
            stage_ff[gi] <= reg_wdata;
          end
          if (upd) begin
            act_ff[gi] <= stage_ff[gi];
          end
        end
      end
      assign act_img[gi*8 +: 8] = act_ff[gi];
    end
  endgenerate

  // Calibration fires only on a committed 0-to-1 step of the bit, so a repeat needs a clear first.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cal_start_ff <= 1'b0;
    end else begin
      cal_start_ff <= upd && stage_ff[`CSCR_IDX_CAL][`CSCR_CAL_BIT] &&
                      !act_ff[`CSCR_IDX_CAL][`CSCR_CAL_BIT];
    end
  end

  // Configuration register reads return the staged copy so software sees what it wrote before the update.
  always @* begin
    case (reg_addr)
      `CSCR_OFS_PLL_CTRL: reg_rdata = stage_ff[`CSCR_IDX_PLL];
      `CSCR_OFS_CAL_CTRL: reg_rdata = stage_ff[`CSCR_IDX_CAL];
      `CSCR_OFS_REF_EN:   reg_rdata = stage_ff[`CSCR_IDX_REF];
      `CSCR_OFS_VCO_DIV:  reg_rdata = stage_ff[`CSCR_IDX_DIV];
      `CSCR_OFS_ROUTE:    reg_rdata = stage_ff[`CSCR_IDX_ROUTE];
      `CSCR_OFS_STATUS:   reg_rdata = {5'h00, vco_enabled, pll_enabled, nv_busy};
      `CSCR_OFS_NV_CTRL:  reg_rdata = {7'h00, nv_busy};
      default:            reg_rdata = 8'h00;
    endcase
  end

  // Decoded controls; only code 00b runs the PLL, every other power code keeps it off.
  assign pll_power_mode   = act_ff[`CSCR_IDX_PLL][`CSCR_PWR_MSB:`CSCR_PWR_LSB];
  assign pll_enabled      = (pll_power_mode == `CSCR_PWR_NORMAL);
  assign pll_powered_down = !pll_enabled;
  assign vco_source_sel   = act_ff[`CSCR_IDX_ROUTE][`CSCR_VCO_SEL_BIT];
  assign vco_enabled      = pll_enabled && vco_source_sel;
  assign ext_to_prescaler = pll_enabled && !vco_source_sel;
  assign div_bypass       = act_ff[`CSCR_IDX_ROUTE][`CSCR_BYP_BIT];
  assign vco_div_code     = act_ff[`CSCR_IDX_DIV][`CSCR_DIV_MSB:0];
  assign pfd_polarity_neg = act_ff[`CSCR_IDX_PLL][`CSCR_PFD_POL_BIT];
  assign ref_input_enable = act_ff[`CSCR_IDX_REF][`CSCR_REF_MSB:0];
  assign vco_cal_start    = cal_start_ff;

  // Divider ratio map; codes above 100b select divide-by-one.
  always @* begin
    case (vco_div_code)
      3'h0:    vco_div_ratio = 3'h2;
      3'h1:    vco_div_ratio = 3'h3;
      3'h2:    vco_div_ratio = 3'h4;
      3'h3:    vco_div_ratio = 3'h5;
      3'h4:    vco_div_ratio = 3'h6;
      default: vco_div_ratio = 3'h1;
    endcase
  end
endmodule // cscr_top

// >>> verification/cscr_top_properties.sv
// Port-level assertions of the clock source routing top module, with their bind.
`timescale 1ns/1ns
module cscr_top_checker (
  input wire logic       clk,              // Clock.
  input wire logic       resetn,           // Reset, active low.
  input wire logic [2:0] nv_addr,          // Memory address.
  input wire logic       nv_re,            // Memory read.
  input wire logic       nv_we,            // Memory write.
  input wire logic [7:0] nv_wdata,         // Memory data.
  input wire logic [1:0] pll_power_mode,   // Power field.
  input wire logic       pll_enabled,      // PLL on.
  input wire logic       pll_powered_down, // PLL off.
  input wire logic       vco_source_sel,   // VCO routed.
  input wire logic       vco_enabled,      // VCO powered.
  input wire logic       ext_to_prescaler, // CLK to prescaler.
  input wire logic       div_bypass,       // Divider skipped.
  input wire logic [2:0] vco_div_code,     // Divider code.
  input wire logic [2:0] vco_div_ratio,    // Ratio.
  input wire logic       vco_cal_start     // Calibration pulse.
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A save burst is six writes from word 0, the last being the marker word.
  sequence save_body;
    (nv_addr == 3'h0) ##0 nv_we [*6] ##1 !nv_we;
  endsequence
  sequence save_mark;
    ##5 (nv_addr == 3'h5 && nv_wdata == 8'ha5);
  endsequence

  AST_PLL_EN: assert property (pll_enabled == (pll_power_mode == 2'h0) && pll_powered_down == !pll_enabled)
    else $error("PLL state differs from power field.");
  AST_VCO_EN: assert property (vco_enabled == (pll_enabled && vco_source_sel))
    else $error("VCO power wrong.");
  AST_EXT_PRE: assert property (ext_to_prescaler == (pll_enabled && !vco_source_sel))
    else $error("Prescaler feed wrong.");
  AST_RATIO: assert property (vco_div_ratio == ((vco_div_code < 3'h5) ? vco_div_code + 3'h2 : 3'h1))
    else $error("Divider ratio wrong.");
  AST_CAL_ONE: assert property (vco_cal_start |=> !vco_cal_start)
    else $error("Calibration pulse too long.");
  AST_RST_DEF: assert property ($rose(resetn) |-> pll_power_mode == 2'h1 && vco_div_code == 3'h0
    && !div_bypass && !vco_source_sel) else $error("Reset defaults wrong.");
  AST_RESTORE_RD: assert property ($rose(resetn) |-> nv_re && nv_addr == 3'h5)
    else $error("Restore does not read marker.");
  AST_SAVE_BURST: assert property ($rose(nv_we) |-> save_body)
    else $error("Save burst malformed.");
  AST_SAVE_MARK: assert property ($rose(nv_we) |-> save_mark)
    else $error("Save marker missing.");
endmodule // cscr_top_checker

bind cscr_top cscr_top_checker cscr_top_checker_i (.clk(clk), .resetn(resetn), .nv_addr(nv_addr), .nv_re(nv_re),
  .nv_we(nv_we), .nv_wdata(nv_wdata), .pll_power_mode(pll_power_mode), .pll_enabled(pll_enabled),
  .pll_powered_down(pll_powered_down), .vco_source_sel(vco_source_sel), .vco_enabled(vco_enabled),
  .ext_to_prescaler(ext_to_prescaler), .div_bypass(div_bypass), .vco_div_code(vco_div_code),
  .vco_div_ratio(vco_div_ratio), .vco_cal_start(vco_cal_start));

// >>> verification/testbench.sv
// Self-checking bench of the clock source routing block, driven over its serial port.
`timescale 1ns/1ns
`define CSCR_CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module testbench;
  typedef struct packed {logic [3:0] id; logic [2:0] idx; logic [7:0] val;} cscr_note_t;
  logic        clk = 1'b0, resetn = 1'b0, spi_sclk = 1'b0, spi_csb_n = 1'b1, spi_sdi = 1'b0, pol = 1'b0;
  wire         spi_sdo, spi_sdo_oe, nv_re, nv_we, pll_enabled, pll_powered_down, vco_source_sel, vco_enabled;
  wire         ext_to_prescaler, div_bypass, pfd_polarity_neg, vco_cal_start;
  wire  [2:0]  nv_addr, vco_div_code, vco_div_ratio, ref_input_enable;
  wire  [1:0]  pll_power_mode;
  wire  [7:0]  nv_wdata;
  logic        oe_seen = 1'b0;
  logic [1:0]  pwr = 2'h1;
  logic [7:0]  nv_rdata = 8'h0, rd_byte = 8'h0, cal_cnt = 8'h0, div_byte = 8'h0;
  logic [7:0]  nv_mem [0:7] = '{default: 8'h0};
  logic [15:0] lfsr = 16'hc65a;
  int          fails = 0, total_checks = 0, cycles = 0;
  cscr_note_t  notes [$];
  event        chk_ev;
  string       what_s [0:11] = '{"power", "pll_state", "vco_en", "ext_pre", "route_pol", "div_code",
                                 "div_ratio", "ref_en", "read_data", "cal_count", "nv_word", "sdo_oe"};

  cscr_top cscr_top_i (
    .clk(clk), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .nv_addr(nv_addr), .nv_re(nv_re), .nv_we(nv_we),
    .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .pll_power_mode(pll_power_mode), .pll_enabled(pll_enabled),
    .pll_powered_down(pll_powered_down), .vco_source_sel(vco_source_sel), .vco_enabled(vco_enabled),
    .ext_to_prescaler(ext_to_prescaler), .div_bypass(div_bypass), .vco_div_code(vco_div_code),
    .vco_div_ratio(vco_div_ratio), .pfd_polarity_neg(pfd_polarity_neg), .ref_input_enable(ref_input_enable),
    .vco_cal_start(vco_cal_start));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Synchronous memory model; read data follows the address by one cycle, like the real part.
  always @(posedge clk) begin
    if (nv_we === 1'b1) nv_mem[nv_addr] <= nv_wdata;
    nv_rdata <= nv_mem[nv_addr];
  end

  // Count calibration pulses and cut a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (vco_cal_start === 1'b1) cal_cnt <= cal_cnt + 8'h1;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Observed value for each kind of note.
  function automatic logic [7:0] obs(input logic [3:0] id, input logic [2:0] idx);
    case (id)
      4'h0: obs = {6'h0, pll_power_mode};
      4'h1: obs = {6'h0, pll_powered_down, pll_enabled};
      4'h2: obs = {7'h0, vco_enabled};
      4'h3: obs = {7'h0, ext_to_prescaler};
      4'h4: obs = {5'h0, vco_source_sel, div_bypass, pfd_polarity_neg};
      4'h5: obs = {5'h0, vco_div_code};
      4'h6: obs = {5'h0, vco_div_ratio};
      4'h7: obs = {5'h0, ref_input_enable};
      4'h8: obs = rd_byte;
      4'h9: obs = cal_cnt;
      4'hb: obs = {7'h0, oe_seen};
      default: obs = nv_mem[idx];
    endcase
  endfunction

  // Second process: each note is taken oldest first and matched against the outputs it names.
  initial forever begin
    cscr_note_t cur;
    @(chk_ev);
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      `CSCR_CHK(what_s[cur.id], cur.val, obs(cur.id, cur.idx))
    end
  end

  task automatic note(input logic [3:0] id, input logic [2:0] idx, input logic [7:0] val);
    notes.push_back('{id, idx, val});
    -> chk_ev;
  endtask

  // Expected decoded controls for one active configuration.
  task automatic expect_cfg(input logic [1:0] p, input logic vs, input logic byp, input logic pl,
                            input logic [2:0] code, input logic [2:0] refs);
    logic on;
    on = (p == 2'h0);
    note(4'h0, 3'h0, {6'h0, p});
    note(4'h1, 3'h0, {6'h0, !on, on});
    note(4'h2, 3'h0, {7'h0, on & vs});
    note(4'h3, 3'h0, {7'h0, on & !vs});
    note(4'h4, 3'h0, {5'h0, vs, byp, pl});
    note(4'h5, 3'h0, {5'h0, code});
    note(4'h6, 3'h0, (code < 3'h5) ? {5'h0, code} + 8'h2 : 8'h1);
    note(4'h7, 3'h0, {5'h0, refs});
  endtask

  // One frame: instruction word then data byte, MSB first; pins change on falling clock edges only.
  task automatic spi_xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd);
    logic [23:0] frame;
    frame = {rd, 2'h0, addr, wd};
    @(negedge clk) spi_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk) spi_sclk = 1'b0;
      spi_sdi = frame[i];
      repeat (8) @(negedge clk);
      if (i < 8) rd_byte[i] = spi_sdo;
      if (i == 0) oe_seen = spi_sdo_oe;
      spi_sclk = 1'b1;
      repeat (8) @(negedge clk);
    end
    spi_sclk = 1'b0;
    repeat (8) @(negedge clk);
    spi_csb_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spi_xfer(1'b0, a, d);
  endtask

  task automatic upd();
    spi_xfer(1'b0, 13'h232, 8'h01);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    spi_xfer(1'b1, a, 8'h00);
    note(4'h8, 3'h0, exp);
    note(4'hb, 3'h0, 8'h01);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (12) @(negedge clk);
    expect_cfg(2'h1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    // Writes stay staged until the update strobe; reads show the staged byte, unmapped reads zero.
    // Selecting the VCO keeps the divider in the path and stages a calibration with it.
    wr(13'h010, 8'h80);
    wr(13'h01c, 8'h05);
    wr(13'h018, 8'h01);
    wr(13'h1e1, 8'h02);
    expect_cfg(2'h1, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    rd_chk(13'h010, 8'h80);
    rd_chk(13'h100, 8'h00);
    upd();
    expect_cfg(2'h0, 1'b1, 1'b0, 1'b1, 3'h0, 3'h5);
    note(4'h9, 3'h0, 8'h01);
    rd_chk(13'h01f, 8'h06);
    // PLL on with the external input selected and the divider bypassed: VCO off, external clock into the prescaler.
    wr(13'h1e1, 8'h01);
    upd();
    expect_cfg(2'h0, 1'b0, 1'b1, 1'b1, 3'h0, 3'h5);
    // Every divider code, with random power code, polarity and unused upper bits.
    for (int c = 0; c < 8; c++) begin
      lfsr = lfsr_next(lfsr);
      pol = lfsr[0];
      pwr = lfsr[2:1];
      div_byte = {lfsr[7:3], c[2:0]};
      wr(13'h010, {pol, 5'h0, pwr});
      wr(13'h1e0, div_byte);
      upd();
      expect_cfg(pwr, 1'b0, 1'b1, pol, c[2:0], 3'h5);
    end
    // A repeat commit of the set bit gives no calibration; a committed clear re-arms it.
    upd();
    note(4'h9, 3'h0, 8'h01);
    wr(13'h018, 8'h00);
    upd();
    wr(13'h018, 8'h01);
    upd();
    note(4'h9, 3'h0, 8'h02);
    // Save the image, then reset and expect it back with no register write.
    wr(13'hb02, 8'h01);
    repeat (12) @(negedge clk);
    note(4'ha, 3'h0, {pol, 5'h0, pwr});
    note(4'ha, 3'h1, 8'h01);
    note(4'ha, 3'h2, 8'h05);
    note(4'ha, 3'h3, div_byte);
    note(4'ha, 3'h4, 8'h01);
    note(4'ha, 3'h5, 8'ha5);
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (20) @(negedge clk);
    expect_cfg(pwr, 1'b0, 1'b1, pol, div_byte[2:0], 3'h5);
    // Let the checking process drain the last notes before the verdict.
    @(negedge clk);
    complete_run();
  end
endmodule // testbench
